// ===== core/isr_cfg.svh
// Purpose: constants of the two-wire slave receive port (offsets, fields, resets)
// Assumes: 32-bit AHB-Lite register bus, word registers at aligned offsets
// Notes:   types live in isr_pkg; this file holds defines only
// Behaviour
// - Start/stop modes set the event flag on Start, Restart and Stop too.
// - First byte after Start is compared; a match loads the buffer, sets flag.
// - Address mismatch returns to idle silently, nothing visible changes.
// - 7-bit mode ignores the read/write bit in the comparison.
// - 10-bit high byte must be 11110, A9, A8, 0; A9/A8 in address bits 2:1.
// - After acking a 10-bit write high byte: refresh request set, SCL held low.
// - 10-bit low byte compares all eight bits; either way flag, refresh, hold.
// - Any write to the address register clears the refresh request.
// - 10-bit read high byte is acked only after a full write match.
// - Matching write address clears read/write status, loads buffer, acks.
// - Address NACKed when buffer full or overflow; overwrite-on-full relaxes this.
// - Event flag set per data byte; only software clears it.
// - Stretch-after-byte holds SCL after each byte until clock release set.
// - Reading the shift buffer clears the buffer-full flag.
// - Start sets start-seen; Stop sets stop-seen and returns to idle.
// - Address hold: after 8th fall flag set, release cleared, SCL stretched.
// - Data hold: after 8th fall flag set, release cleared, SCL stretched.
// - An ack-phase status bit tells events before and after the ack apart.
// - In hold modes the chosen ack value is driven after clock release.
// - Flag set at 9th fall after an ACK; left clear after a NACK.
// - Hold modes with stretch-after-byte also stretch after the ack.
// - Reception ends on NACK or Stop; stop-seen is pollable.
// - With both holds off the ack is generated by hardware.
// - Ack-phase bit set after the 8th fall when the hold mode of that phase is on.
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH

// ==========================================
// register map
`define ISR_OFF_CTRL     8'h00
`define ISR_OFF_STATUS   8'h04
`define ISR_OFF_ADDR     8'h08
`define ISR_OFF_BUF      8'h0C
`define ISR_OFF_W        8

// ==========================================
// fields
`define ISR_MODE_TEN     0
`define ISR_MODE_SP      1
`define ISR_ST_EVT       0
`define ISR_ST_OVF       1
`define ISR_TEN_PFX      5'h1E
`define ISR_BYTE_LAST    4'h8
`define ISR_HSIZE_WORD   3'h2
`define ISR_HTRANS_ACT   1

// ==========================================
// reset values
`define ISR_RST_BYTE     8'h00
`define ISR_RST_WORD     32'h0000_0000
`define ISR_RST_PINS     3'h7

`endif

// ===== core/isr_pkg.sv
// Purpose: types of the two-wire slave receive port
// Assumes: constants come from isr_cfg.svh
// Notes:   control register travels as one packed struct
`default_nettype none
package isr_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_HOLD8,
		ST_ACK,
		ST_POST,
		ST_UA
	} isr_state_t;

	typedef enum logic [1:0] {
		PH_ADDR,
		PH_ADDR_LO,
		PH_DATA
	} isr_phase_t;

	typedef struct packed {
		logic       clock_release;
		logic       ack_value_select;
		logic       overwrite_on_full;
		logic       data_hold_enable;
		logic       addr_hold_enable;
		logic       stretch_after_byte;
		logic [1:0] serial_mode_select;
	} isr_ctrl_t;

endpackage

`default_nettype wire

// ===== core/isr_slave.sv
// Purpose: two-wire slave address match and byte reception behind AHB-Lite
// Assumes: scl_i/sda_i are asynchronous pin levels; mclk_i much faster than SCL
// Notes:   slave transmission is not implemented; a read match acks and stretches
`timescale 1ns/100ps
`default_nettype none
`include "isr_cfg.svh"

module isr_slave
	import isr_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	output logic             sda_o,
	output logic             sda_oe_o
);

	// ==========================================
	// pin synchronisers: [0] meta, [1] synced, [2] previous
	logic [2:0]  scl_sy;
	logic [2:0]  sda_sy;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			scl_sy <= `ISR_RST_PINS;
			sda_sy <= `ISR_RST_PINS;
		end else begin
			scl_sy <= {scl_sy[1:0], scl_i};
			sda_sy <= {sda_sy[1:0], sda_i};
		end
	end

	assign scl_rise  = scl_sy[1] & ~scl_sy[2];
	assign scl_fall  = ~scl_sy[1] & scl_sy[2];
	assign start_det = scl_sy[1] & scl_sy[2] & sda_sy[2] & ~sda_sy[1];
	assign stop_det  = scl_sy[1] & scl_sy[2] & ~sda_sy[2] & sda_sy[1];

	// ==========================================
	// registers and state
	isr_state_t  state;
	isr_state_t  next_state;
	isr_phase_t  phase;
	isr_phase_t  next_phase;
	isr_ctrl_t   ctrl;
	isr_ctrl_t   next_ctrl;
	logic [3:0]  bitcnt;
	logic [7:0]  shreg;
	logic [7:0]  slave_addr;
	logic [7:0]  rx_buf;
	logic        ack_bit;
	logic        next_ack;
	logic        rd_match;
	logic        next_rd;
	logic        prior_match;
	logic        next_prior;
	logic        lo_miss;
	logic        next_lo_miss;
	logic        evt_flag;
	logic        rx_ovf;
	logic        bf;
	logic        ua;
	logic        rw_stat;
	logic        data_stat;
	logic        start_seen;
	logic        stop_seen;
	logic        ack_phase;
	logic        evt_set;
	logic        ua_set;
	logic        ckp_clr;
	logic        buf_load;
	logic        ovf_set;
	logic        ackt_set;
	logic        ackt_clr;
	logic        rw_load;

	// ==========================================
	// bus slave decode
	logic        acc;
	logic        rd_acc;
	logic        wr_acc;
	logic        wr_pend;
	logic [7:0]  wr_off;
	logic        wr_ctrl;
	logic        wr_stat;
	logic        wr_addr;
	logic        buf_read;
	logic [31:0] rd_word;
	logic        clr_evt;
	logic        clr_ovf;

	// zero wait states, so the data phase always follows one cycle after acceptance
	assign acc      = hsel_i & htrans_i[`ISR_HTRANS_ACT] & hready_i & (hsize_i == `ISR_HSIZE_WORD);
	assign rd_acc   = acc & ~hwrite_i;
	assign wr_acc   = acc & hwrite_i;
	assign wr_ctrl  = wr_pend & (wr_off == `ISR_OFF_CTRL);
	assign wr_stat  = wr_pend & (wr_off == `ISR_OFF_STATUS);
	assign wr_addr  = wr_pend & (wr_off == `ISR_OFF_ADDR);
	assign buf_read = rd_acc & (haddr_i[`ISR_OFF_W-1:0] == `ISR_OFF_BUF);
	assign clr_evt  = wr_stat & hwdata_i[`ISR_ST_EVT];
	assign clr_ovf  = wr_stat & hwdata_i[`ISR_ST_OVF];

	assign rd_word =
		(haddr_i[`ISR_OFF_W-1:0] == `ISR_OFF_CTRL)   ? {24'h00_0000, ctrl} :
		(haddr_i[`ISR_OFF_W-1:0] == `ISR_OFF_STATUS) ? {23'h00_0000, ack_phase, stop_seen, start_seen,
			data_stat, rw_stat, ua, bf, rx_ovf, evt_flag} :
		(haddr_i[`ISR_OFF_W-1:0] == `ISR_OFF_ADDR)   ? {24'h00_0000, slave_addr} :
		(haddr_i[`ISR_OFF_W-1:0] == `ISR_OFF_BUF)    ? {24'h00_0000, rx_buf} :
		`ISR_RST_WORD;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			wr_pend     <= 1'b0;
			wr_off      <= `ISR_RST_BYTE;
			hrdata_o    <= `ISR_RST_WORD;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			wr_pend     <= wr_acc;
			wr_off      <= haddr_i[`ISR_OFF_W-1:0];
			hrdata_o    <= rd_acc ? rd_word : `ISR_RST_WORD;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
	end

	// ==========================================
	// address decode on the received byte
	logic ten_bit;
	logic sp_int;
	logic addr_hit;
	logic lo_hit;
	logic hold_now;
	logic nack_ovf;
	logic byte_done;

	assign ten_bit   = ctrl.serial_mode_select[`ISR_MODE_TEN];
	assign sp_int    = ctrl.serial_mode_select[`ISR_MODE_SP];
	assign addr_hit  = ten_bit ?
		((shreg[7:3] == `ISR_TEN_PFX) && (shreg[2:1] == slave_addr[2:1]) && (!shreg[0] || prior_match)) :
		(shreg[7:1] == slave_addr[7:1]);
	assign lo_hit    = (shreg == slave_addr);
	assign hold_now  = (phase == PH_DATA) ? ctrl.data_hold_enable : ctrl.addr_hold_enable;
	// overwrite-on-full lets a full buffer be replaced, but an existing overflow still refuses
	assign nack_ovf  = rx_ovf | (bf & ~ctrl.overwrite_on_full);
	assign byte_done = (state == ST_RX) && scl_fall && (bitcnt == `ISR_BYTE_LAST);

	// ==========================================
	// byte sequencer
	always_comb begin
		next_state   = state;
		next_phase   = phase;
		next_ack     = ack_bit;
		next_rd      = rd_match;
		next_prior   = prior_match;
		next_lo_miss = lo_miss;
		evt_set      = 1'b0;
		ua_set       = 1'b0;
		ckp_clr      = 1'b0;
		buf_load     = 1'b0;
		ovf_set      = 1'b0;
		ackt_set     = 1'b0;
		ackt_clr     = 1'b0;
		rw_load      = 1'b0;
		if (stop_det) begin
			next_state = ST_IDLE;
			next_prior = 1'b0;
			evt_set    = sp_int;
			ackt_clr   = 1'b1;
		end else if (start_det) begin
			next_state   = ST_RX;
			next_phase   = PH_ADDR;
			next_rd      = 1'b0;
			next_lo_miss = 1'b0;
			evt_set      = sp_int;
			ackt_clr     = 1'b1;
		end else begin
			unique case (state)
				ST_IDLE: begin
				end
				ST_RX: begin
					if (byte_done) begin
						if ((phase == PH_ADDR) && !addr_hit) begin
							next_state = ST_IDLE;
							next_prior = ten_bit ? 1'b0 : prior_match;
						end else if ((phase == PH_ADDR_LO) && !lo_hit) begin
							evt_set      = 1'b1;
							ua_set       = 1'b1;
							next_lo_miss = 1'b1;
							next_state   = ST_UA;
						end else begin
							buf_load = !nack_ovf;
							ovf_set  = bf;
							ackt_set = hold_now;
							if (phase == PH_ADDR) begin
								rw_load = 1'b1;
								next_rd = shreg[0];
								if (ten_bit && !shreg[0]) begin
									next_prior = 1'b0;
								end
							end
							if (hold_now) begin
								evt_set    = 1'b1;
								ckp_clr    = 1'b1;
								next_state = ST_HOLD8;
							end else begin
								next_ack   = !nack_ovf;
								next_state = ST_ACK;
							end
						end
					end
				end
				ST_HOLD8: begin
					if (ctrl.clock_release) begin
						next_ack   = !ctrl.ack_value_select;
						next_state = ST_ACK;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						ackt_clr = 1'b1;
						if (!ack_bit) begin
							next_state = ST_IDLE;
						end else begin
							evt_set = 1'b1;
							if (ten_bit && (phase == PH_ADDR) && !rd_match) begin
								ua_set     = 1'b1;
								next_phase = PH_ADDR_LO;
								next_state = ST_UA;
							end else if (phase == PH_ADDR_LO) begin
								ua_set     = 1'b1;
								next_prior = 1'b1;
								next_phase = PH_DATA;
								next_state = ST_UA;
							end else begin
								next_phase = PH_DATA;
								if (rd_match || ctrl.stretch_after_byte) begin
									ckp_clr    = 1'b1;
									next_state = ST_POST;
								end else begin
									next_state = ST_RX;
								end
							end
						end
					end
				end
				ST_POST: begin
					if (ctrl.clock_release) begin
						// transmit side absent: a read request ends here
						next_state = rd_match ? ST_IDLE : ST_RX;
					end
				end
				ST_UA: begin
					if (!ua) begin
						next_state   = lo_miss ? ST_IDLE : ST_RX;
						next_lo_miss = 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state       <= ST_IDLE;
			phase       <= PH_ADDR;
			ack_bit     <= 1'b0;
			rd_match    <= 1'b0;
			prior_match <= 1'b0;
			lo_miss     <= 1'b0;
		end else begin
			state       <= next_state;
			phase       <= next_phase;
			ack_bit     <= next_ack;
			rd_match    <= next_rd;
			prior_match <= next_prior;
			lo_miss     <= next_lo_miss;
		end
	end

	// bits shift in on rising SCL, counter clears whenever not receiving
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || start_det || (state != ST_RX)) begin
			bitcnt <= 4'h0;
		end else if (scl_rise && (bitcnt != `ISR_BYTE_LAST)) begin
			bitcnt <= bitcnt + 4'h1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			shreg <= `ISR_RST_BYTE;
		end else if ((state == ST_RX) && scl_rise) begin
			shreg <= {shreg[6:0], sda_sy[1]};
		end
	end

	// ==========================================
	// software visible state; hardware set wins over software clear
	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = isr_ctrl_t'(hwdata_i[7:0]);
		end
		// a hardware hold must not be lost to a coincident write
		if (ckp_clr) begin
			next_ctrl.clock_release = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ctrl       <= isr_ctrl_t'(`ISR_RST_BYTE);
			slave_addr <= `ISR_RST_BYTE;
			rx_buf     <= `ISR_RST_BYTE;
			evt_flag   <= 1'b0;
			rx_ovf     <= 1'b0;
			bf         <= 1'b0;
			ua         <= 1'b0;
			rw_stat    <= 1'b0;
			data_stat  <= 1'b0;
			start_seen <= 1'b0;
			stop_seen  <= 1'b0;
			ack_phase  <= 1'b0;
		end else begin
			ctrl       <= next_ctrl;
			slave_addr <= wr_addr ? hwdata_i[7:0] : slave_addr;
			rx_buf     <= buf_load ? shreg : rx_buf;
			evt_flag   <= evt_set | (evt_flag & ~clr_evt);
			rx_ovf     <= ovf_set | (rx_ovf & ~clr_ovf);
			bf         <= buf_load | (bf & ~buf_read);
			ua         <= ua_set | (ua & ~wr_addr);
			rw_stat    <= rw_load ? shreg[0] : rw_stat;
			data_stat  <= buf_load ? (phase == PH_DATA) : data_stat;
			start_seen <= start_det | (start_seen & ~stop_det);
			stop_seen  <= stop_det | (stop_seen & ~start_det);
			ack_phase  <= ackt_set | (ack_phase & ~ackt_clr);
		end
	end

	// ==========================================
	// open-drain pins, both registered
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			scl_o    <= 1'b0;
			sda_o    <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			scl_o    <= 1'b0;
			sda_o    <= 1'b0;
			scl_oe_o <= (next_state == ST_HOLD8) || (next_state == ST_POST) || (next_state == ST_UA);
			sda_oe_o <= (next_state == ST_ACK) && next_ack;
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_hold_enter;
		byte_done && (phase != PH_ADDR_LO) && ((phase != PH_ADDR) || addr_hit) && hold_now;
	endsequence

	sequence s_released;
		(state == ST_HOLD8) && ctrl.clock_release && !start_det && !stop_det;
	endsequence

	property p_start_flag;
		start_det && sp_int |=> evt_flag;
	endproperty
	a_start_flag: assert property (p_start_flag) else $error("start did not raise event flag");

	property p_nomatch;
		byte_done && (phase == PH_ADDR) && !addr_hit
			|=> ((state == ST_IDLE) && $stable(rx_buf) && !$rose(bf) && !$rose(evt_flag))[*2];
	endproperty
	a_nomatch: assert property (p_nomatch) else $error("mismatch left visible trace");

	property p_hold;
		s_hold_enter |=> (state == ST_HOLD8) && scl_oe_o && evt_flag && ack_phase && !ctrl.clock_release;
	endproperty
	a_hold: assert property (p_hold) else $error("hold did not stretch before ack");

	property p_release;
		s_released |=> (state == ST_ACK) && (sda_oe_o == !$past(ctrl.ack_value_select)) ##1 !scl_oe_o;
	endproperty
	a_release: assert property (p_release) else $error("chosen ack value not driven");

	property p_ua_clear;
		wr_addr && !ua_set |=> !ua;
	endproperty
	a_ua_clear: assert property (p_ua_clear) else $error("address write kept refresh request");

	property p_bf_clear;
		buf_read && !buf_load |=> !bf;
	endproperty
	a_bf_clear: assert property (p_bf_clear) else $error("buffer read kept full flag");

	property p_flag_sticky;
		evt_flag && !clr_evt |=> evt_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("event flag cleared by hardware");

	property p_ovf_nack;
		byte_done && (phase == PH_ADDR) && addr_hit && nack_ovf && !hold_now |=> (state == ST_ACK) && !sda_oe_o;
	endproperty
	a_ovf_nack: assert property (p_ovf_nack) else $error("overflowed address was acked");

	property p_stop;
		stop_det |=> stop_seen && !start_seen && (state == ST_IDLE) && !scl_oe_o && !sda_oe_o;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not recorded");

	property p_nack_idle;
		(state == ST_ACK) && !ack_bit && scl_fall && !start_det && !stop_det
			|=> (state == ST_IDLE) && !sda_oe_o && !scl_oe_o && ($stable(evt_flag) || $fell(evt_flag));
	endproperty
	a_nack_idle: assert property (p_nack_idle) else $error("nack did not release bus");

endmodule

`default_nettype wire

// ===== verification/isr_mst.sv
// Purpose: behavioural two-wire bus master facing the slave port
// Assumes: open-drain wires resolved in the bench with pull-ups
// Notes:   SCL moves only inside frames; every rise waits out stretching
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// bus master model
module isr_mst (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_pull_o,
	output logic      sda_pull_o
);
	int stuck;

	initial begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
		stuck      = 0;
	end

	// bounded wait, so a slave that never releases cannot hang the run
	task automatic rise();
		int n;
		n = 0;
		scl_pull_o = 1'b0;
		while (scl_i !== 1'b1 && n < 400) begin
			#50;
			n++;
		end
		if (n >= 400) stuck++;
		#400;
	endtask

	// also serves as restart: sda released first, then clocked high
	task automatic start();
		sda_pull_o = 1'b0;
		#200;
		rise();
		sda_pull_o = 1'b1;
		#400;
		scl_pull_o = 1'b1;
		#200;
	endtask

	task automatic stop();
		sda_pull_o = 1'b1;
		#200;
		rise();
		sda_pull_o = 1'b0;
		#800;
	endtask

	task automatic bits(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sda_pull_o = ~b[i];
			#200;
			rise();
			scl_pull_o = 1'b1;
			#200;
		end
		sda_pull_o = 1'b0;
		#300;
	endtask

	// sampled just before the fall, while the slave still holds SDA
	task automatic ackb(output logic a);
		#100;
		rise();
		a = (sda_i === 1'b0);
		scl_pull_o = 1'b1;
		#400;
	endtask
endmodule

`default_nettype wire

// ===== verification/test_isr_slave.sv
// Purpose: self-checking bench of the two-wire slave receive port
// Assumes: zero-wait AHB-Lite slave, bus master model on the pins
// Notes:   expected buffer bytes kept in a queue, popped on each rdbuf read
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// bench
module test_isr_slave;
	import isr_pkg::*;
	logic        mclk, rst, hsel, hwrite;
	logic [31:0] haddr, hwdata, rv;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda;
	wire         scl = ~(m_scl | scl_oe);
	wire         sda = ~(m_sda | sda_oe);
	int          error_cnt, checked, cyc;
	logic [7:0]  exp_q[$];
	logic [7:0]  d;
	logic [6:0]  a7;
	logic [9:0]  a10;
	logic        a;
	isr_ctrl_t   ctrl;

	isr_slave isr_slave_inst (.mclk_i(mclk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
		.hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .scl_i(scl), .sda_i(sda),
		.scl_o(scl_o), .scl_oe_o(scl_oe), .sda_o(sda_o), .sda_oe_o(sda_oe));
	isr_mst isr_mst_inst (.scl_i(scl), .sda_i(sda), .scl_pull_o(m_scl), .sda_pull_o(m_sda));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic close_out();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard, well above the fewer than two thousand cycles the run needs
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// no wait-state count assumed: only the hang guard ends a wait
	task automatic rdy();
		do begin
			@(posedge mclk);
		end while (hreadyout !== 1'b1);
	endtask

	task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] wd);
		@(posedge mclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, ad};
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		rv = hrdata;
	endtask

	task automatic st(input int b, input logic e);
		bus(8'h04, 1'b0, 32'h0);
		chk(rv[b], e);
	endtask

	task automatic rdbuf();
		bus(8'h0C, 1'b0, 32'h0);
		chk(rv, exp_q.pop_front());
	endtask

	task automatic xfer(input logic [7:0] b, input logic ack);
		isr_mst_inst.bits(b);
		isr_mst_inst.ackb(a);
		chk(a, ack);
		if (ack) exp_q.push_back(b);
	endtask

	task automatic wctl();
		bus(8'h00, 1'b1, {24'h000000, ctrl});
	endtask

	initial begin
		{hsel, hwrite, haddr, hwdata, htrans, ctrl} = '0;
		hsize = 3'h2;
		rst   = 1'b1;
		void'($urandom(59654));
		a7  = 7'($urandom_range(8, 119));
		a10 = 10'($urandom);
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		bus(8'h10, 1'b1, 32'hFFFF_FFFF);
		bus(8'h10, 1'b0, 32'h0);
		chk(rv, 32'h0);
		bus(8'h08, 1'b1, {24'h000000, a7, 1'b0});
		// ==========================================
		// 7-bit write with start/stop events
		ctrl.serial_mode_select = 2'h2;
		wctl();
		isr_mst_inst.start();
		st(0, 1'b1);
		st(6, 1'b1);
		bus(8'h04, 1'b1, 32'h3);
		xfer({a7, 1'b0}, 1'b1);
		st(0, 1'b1);
		st(4, 1'b0);
		rdbuf();
		st(2, 1'b0);
		bus(8'h04, 1'b1, 32'h3);
		d = 8'($urandom);
		xfer(d, 1'b1);
		st(0, 1'b1);
		rdbuf();
		bus(8'h04, 1'b1, 32'h3);
		isr_mst_inst.stop();
		st(7, 1'b1);
		st(0, 1'b1);
		// ==========================================
		// read bit ignored by the match; mismatch stays silent
		ctrl = '0;
		ctrl.clock_release = 1'b1;
		wctl();
		bus(8'h04, 1'b1, 32'h3);
		isr_mst_inst.start();
		xfer({a7, 1'b1}, 1'b1);
		st(4, 1'b1);
		rdbuf();
		wctl();
		isr_mst_inst.stop();
		bus(8'h04, 1'b1, 32'h3);
		isr_mst_inst.start();
		xfer({a7 ^ 7'h01, 1'b0}, 1'b0);
		st(0, 1'b0);
		st(2, 1'b0);
		chk(sda_oe, 1'b0);
		isr_mst_inst.stop();
		// ==========================================
		// full buffer refuses the next address
		isr_mst_inst.start();
		xfer({a7, 1'b0}, 1'b1);
		isr_mst_inst.stop();
		isr_mst_inst.start();
		xfer({a7, 1'b0}, 1'b0);
		st(1, 1'b1);
		isr_mst_inst.stop();
		rdbuf();
		bus(8'h04, 1'b1, 32'h3);
		// ==========================================
		// stretch after each byte
		ctrl.stretch_after_byte = 1'b1;
		ctrl.clock_release      = 1'b0;
		wctl();
		isr_mst_inst.start();
		xfer({a7, 1'b0}, 1'b1);
		chk(scl_oe, 1'b1);
		rdbuf();
		ctrl.clock_release = 1'b1;
		wctl();
		// control lands at the data-phase edge, the pin one edge later
		repeat (2) @(posedge mclk);
		chk(scl_oe, 1'b0);
		// ==========================================
		// address and data hold, software picks the ack
		ctrl.addr_hold_enable = 1'b1;
		ctrl.data_hold_enable = 1'b1;
		ctrl.clock_release    = 1'b0;
		wctl();
		bus(8'h04, 1'b1, 32'h3);
		isr_mst_inst.start();
		isr_mst_inst.bits({a7, 1'b0});
		st(0, 1'b1);
		st(8, 1'b1);
		chk(scl_oe, 1'b1);
		bus(8'h00, 1'b0, 32'h0);
		chk(rv[7], 1'b0);
		bus(8'h04, 1'b1, 32'h3);
		ctrl.clock_release = 1'b1;
		wctl();
		isr_mst_inst.ackb(a);
		chk(a, 1'b1);
		st(8, 1'b0);
		st(0, 1'b1);
		chk(scl_oe, 1'b1);
		bus(8'h0C, 1'b0, 32'h0);
		chk(rv, {24'h000000, a7, 1'b0});
		bus(8'h04, 1'b1, 32'h3);
		wctl();
		isr_mst_inst.bits(8'($urandom));
		st(0, 1'b1);
		bus(8'h04, 1'b1, 32'h3);
		ctrl.ack_value_select = 1'b1;
		wctl();
		isr_mst_inst.ackb(a);
		chk(a, 1'b0);
		st(0, 1'b0);
		chk(scl_oe, 1'b0);
		isr_mst_inst.stop();
		bus(8'h0C, 1'b0, 32'h0);
		exp_q.delete();
		// ==========================================
		// 10-bit: full write match, then read on restart
		ctrl = '0;
		ctrl.serial_mode_select = 2'h1;
		wctl();
		bus(8'h08, 1'b1, {24'h000000, 5'h1E, a10[9:8], 1'b0});
		bus(8'h04, 1'b1, 32'h3);
		isr_mst_inst.start();
		xfer({5'h1E, a10[9:8], 1'b0}, 1'b1);
		st(3, 1'b1);
		chk(scl_oe, 1'b1);
		rdbuf();
		bus(8'h08, 1'b1, {24'h000000, a10[7:0]});
		st(3, 1'b0);
		bus(8'h04, 1'b1, 32'h3);
		xfer(a10[7:0], 1'b1);
		st(0, 1'b1);
		st(3, 1'b1);
		rdbuf();
		bus(8'h08, 1'b1, {24'h000000, 5'h1E, a10[9:8], 1'b0});
		xfer(8'($urandom), 1'b1);
		rdbuf();
		isr_mst_inst.start();
		xfer({5'h1E, a10[9:8], 1'b1}, 1'b1);
		rdbuf();
		ctrl.clock_release = 1'b1;
		wctl();
		isr_mst_inst.stop();
		bus(8'h04, 1'b1, 32'h3);
		isr_mst_inst.start();
		xfer({5'h1E, a10[9:8], 1'b0}, 1'b1);
		bus(8'h08, 1'b1, {24'h000000, a10[7:0]});
		bus(8'h04, 1'b1, 32'h3);
		isr_mst_inst.bits(a10[7:0] ^ 8'h01);
		st(0, 1'b1);
		st(3, 1'b1);
		chk(scl_oe, 1'b1);
		bus(8'h08, 1'b1, {24'h000000, 5'h1E, a10[9:8], 1'b0});
		isr_mst_inst.ackb(a);
		chk(a, 1'b0);
		isr_mst_inst.stop();
		rdbuf();
		chk({hresp, scl_o, sda_o}, 32'h0);
		chk(isr_mst_inst.stuck, 0);
		close_out();
	end
endmodule

`default_nettype wire
